// ===== hdl/cbl_defines.vh
// constants for the locked byte-lane bus cycle unit
`ifndef CBL_DEFINES_VH
`define CBL_DEFINES_VH
// bus T states, one clock each
`define CBL_ST_TI 3'h0
`define CBL_ST_TP 3'h1
`define CBL_ST_T1 3'h2
`define CBL_ST_T2 3'h3
`define CBL_ST_T3 3'h4
`define CBL_ST_TW 3'h5
`define CBL_ST_T4 3'h6
// cycle status codes
`define CBL_CS_RDIO  3'h1
`define CBL_CS_WRIO  3'h2
`define CBL_CS_FETCH 3'h4
`define CBL_CS_RDMEM 3'h5
`define CBL_CS_WRMEM 3'h6
`define CBL_CS_IDLE  3'h7
// lock release: T states from start of last locked cycle
`define CBL_LOCK_REL 2'h3
// request fifo layout
`define CBL_FIFO_W     42
`define CBL_FIFO_D     8
`define CBL_F_LOCK     41
`define CBL_F_LAST     40
`define CBL_F_FETCH    39
`define CBL_F_IO       38
`define CBL_F_WRITE    37
`define CBL_F_WORD     36
`define CBL_F_ADDR_HI  35
`define CBL_F_ADDR_LO  16
`endif

// ===== hdl/cbl_fifo.v
// small synchronous fifo with valid/ready on both sides
module cbl_fifo #(
  parameter WIDTH = 42,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk,   // clock
  input  wire             rst_n,     // sync reset, low
  input  wire             inValid,   // write side valid
  output wire             inReady,   // not full
  input  wire [WIDTH-1:0] inData,    // write data
  output wire             outValid,  // not empty
  input  wire             outReady,  // read side takes head
  output wire [WIDTH-1:0] outData    // head entry
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      count;
  reg             full;
  reg             empty;
  wire            doWr = inValid & ~full;
  wire            doRd = outReady & ~empty;
  wire [AW:0]     next_count = count + {{AW{1'b0}}, doWr}
                              - {{AW{1'b0}}, doRd};
  assign inReady  = ~full;
  assign outValid = ~empty;
  assign outData  = mem[rdPtr];
  // storage write
  always @(posedge ref_clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end
  // pointers and honest flags
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      full  <= 1'b0;
      empty <= 1'b1;
    end else begin
      if (doWr) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= next_count;
      full  <= (next_count == DEPTH);
      empty <= (next_count == {(AW+1){1'b0}});
    end
  end
endmodule

// ===== hdl/cbl_bus_unit.v
// bus cycle engine: lock, coprocessor wait and byte-lane steering
`include "cbl_defines.vh"
module cbl_bus_unit (
  input  wire        ref_clk,           // 40 MHz clock
  input  wire        rst_n,             // sync reset, low
  input  wire        reqValid,          // bus request offered
  output wire        reqReady,          // request queue not full
  input  wire        reqWrite,          // 1 write, 0 read
  input  wire        reqWord,           // 1 word, 0 byte
  input  wire        reqIo,             // 1 io space
  input  wire        reqFetch,          // opcode prefetch
  input  wire        reqLast,           // last data cycle of instr
  input  wire [19:0] reqAddr,           // byte address
  input  wire [15:0] reqWrData,         // write data, byte in [7:0]
  input  wire        lockPrefix,        // lock prefix decoded, pulse
  input  wire        instrEnd,          // instruction retired, pulse
  input  wire        waitInstr,         // coproc wait decoded, pulse
  output reg         execStall,         // execution suspended
  input  wire        coprocIdle_n,      // pin, low when idle
  input  wire        holdReq,           // pin, hold request
  output reg         holdAck,           // hold acknowledge
  input  wire        dmaReq,            // internal dma wants bus
  output reg         dmaGrant,          // dma may run cycles
  input  wire        ready,             // pin, cycle may end
  input  wire [15:0] adIn,              // address/data pins in
  output reg  [15:0] adOut,             // address/data pins out
  output reg         adOe_n,            // low while driving ad
  output reg  [3:0]  addrHigh,          // upper address bits
  output reg         byteSelectLsb,     // address bit 0
  output reg         upperByteEnable_n, // upper lane enable, low
  output reg  [2:0]  cycleStatus,       // cycle status lines
  output reg         lock_n,            // bus lock, low
  output reg         rdValid,           // read data valid, pulse
  output reg  [15:0] rdData             // read result
);
  // pin synchronisers: stage one feeds stage two only
  reg [18:0] pinS1;
  reg [18:0] pinS2;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pinS1 <= 19'h7_ffff;
      pinS2 <= 19'h7_ffff;
    end else begin
      pinS1 <= {coprocIdle_n, holdReq, ready, adIn};
      pinS2 <= pinS1;
    end
  end
  wire        idleSync  = ~pinS2[18];
  wire        holdSync  = pinS2[17];
  wire        readySync = pinS2[16];
  wire [15:0] adSync    = pinS2[15:0];

  // lock prefix arming; set wins over clear
  reg prefixArmed;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      prefixArmed <= 1'b0;
    end else if (lockPrefix) begin
      prefixArmed <= 1'b1;
    end else if (instrEnd) begin
      prefixArmed <= 1'b0;
    end
  end

  // coprocessor wait; new wait wins over idle clear
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      execStall <= 1'b0;
    end else if (waitInstr) begin
      execStall <= 1'b1;
    end else if (idleSync) begin
      execStall <= 1'b0;
    end
  end

  // request queue in the data path
  wire [41:0] pushData;
  wire [41:0] head;
  wire        headValid;
  wire        pop;
  assign pushData = {prefixArmed & ~reqFetch,
                     reqLast, reqFetch, reqIo, reqWrite, reqWord,
                     reqAddr, reqWrData};
  cbl_fifo #(
    .WIDTH (`CBL_FIFO_W),
    .DEPTH (`CBL_FIFO_D),
    .AW    (3)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inValid  (reqValid),
    .inReady  (reqReady),
    .inData   (pushData),
    .outValid (headValid),
    .outReady (pop),
    .outData  (head)
  );

  // current cycle
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [19:0] curAddr;
  reg [15:0] curData;
  reg        curWrite;
  reg        curWord;
  reg        curIo;
  reg        curFetch;
  reg        curLock;
  reg        curLast;
  reg        splitFirst;   // first half of odd word
  reg        splitSecond;  // second half of odd word
  reg        endNext;      // this T3/Tw is the last
  reg        lockActive;
  reg [1:0]  relCnt;
  reg [7:0]  lowHalf;

  // start a new cycle only when no one else owns the bus
  wire headLock  = head[`CBL_F_LOCK];
  wire headFetch = head[`CBL_F_FETCH];
  wire startOk = headValid & ~holdAck & ~dmaGrant
                 & ~(lockActive & headFetch);
  assign pop = (state == `CBL_ST_TI) & startOk;
  wire holdNow = holdSync & ~lockActive & ~holdAck;
  wire dmaNow  = dmaReq & ~lockActive & ~dmaGrant;

  // cycle kind from the flags
  wire [1:0] kind = {curWrite, ~curWrite};
  reg  [2:0] activeCode;
  always @* begin
    if (curFetch) begin
      activeCode = `CBL_CS_FETCH;
    end else if (curIo) begin
      activeCode = curWrite ? `CBL_CS_WRIO : `CBL_CS_RDIO;
    end else begin
      activeCode = curWrite ? `CBL_CS_WRMEM : `CBL_CS_RDMEM;
    end
  end

  // lane choice for the half now being run
  wire oddHalf  = curAddr[0];
  wire wordBoth = curWord & ~curAddr[0] & ~splitSecond;
  wire useUpper = wordBoth | oddHalf;
  wire useLower = wordBoth | ~oddHalf;

  // state sequence
  always @* begin
    next_state = state;
    case (state)
      `CBL_ST_TI: begin
        if (pop) begin
          next_state = `CBL_ST_TP;
        end
      end
      `CBL_ST_TP: next_state = `CBL_ST_T1;
      `CBL_ST_T1: next_state = `CBL_ST_T2;
      `CBL_ST_T2: next_state = `CBL_ST_T3;
      `CBL_ST_T3: next_state = endNext ? `CBL_ST_T4 : `CBL_ST_TW;
      `CBL_ST_TW: next_state = endNext ? `CBL_ST_T4 : `CBL_ST_TW;
      `CBL_ST_T4: begin
        next_state = splitFirst ? `CBL_ST_TP : `CBL_ST_TI;
      end
      default: next_state = `CBL_ST_TI;
    endcase
  end

  // engine registers
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state       <= `CBL_ST_TI;
      curAddr     <= 20'h0_0000;
      curData     <= 16'h0000;
      curWrite    <= 1'b0;
      curWord     <= 1'b0;
      curIo       <= 1'b0;
      curFetch    <= 1'b0;
      curLock     <= 1'b0;
      curLast     <= 1'b0;
      splitFirst  <= 1'b0;
      splitSecond <= 1'b0;
      endNext     <= 1'b0;
      lowHalf     <= 8'h00;
    end else begin
      state <= next_state;
      if (pop) begin
        curAddr     <= head[`CBL_F_ADDR_HI:`CBL_F_ADDR_LO];
        curData     <= head[15:0];
        curWrite    <= head[`CBL_F_WRITE];
        curWord     <= head[`CBL_F_WORD];
        curIo       <= head[`CBL_F_IO];
        curFetch    <= headFetch;
        curLock     <= headLock;
        curLast     <= head[`CBL_F_LAST];
        splitFirst  <= head[`CBL_F_WORD] & head[`CBL_F_ADDR_LO];
        splitSecond <= 1'b0;
      end
      // ready decides at entry of T3 / Tw whether T4 follows
      if (next_state == `CBL_ST_T3 || next_state == `CBL_ST_TW) begin
        endNext <= readySync;
      end
      // odd word: move to next even byte after first half
      if (state == `CBL_ST_T4 && splitFirst) begin
        curAddr     <= curAddr + 20'h0_0001;
        splitFirst  <= 1'b0;
        splitSecond <= 1'b1;
      end
      if (state == `CBL_ST_T4 && !splitFirst) begin
        splitSecond <= 1'b0;
      end
      // first half of odd word read keeps its byte
      if (next_state == `CBL_ST_T4 && splitFirst) begin
        lowHalf <= adSync[15:8];
      end
    end
  end

  // values for the coming cycle, seen in the state before TP (TI or T4)
  wire [19:0] preAddr = (state == `CBL_ST_TI)
                        ? head[`CBL_F_ADDR_HI:`CBL_F_ADDR_LO]
                        : curAddr + 20'h0_0001;
  wire preWord  = (state == `CBL_ST_TI) ? head[`CBL_F_WORD] : 1'b0;
  wire preUpper = preAddr[0] | preWord;
  wire preWrite = (state == `CBL_ST_TI) ? head[`CBL_F_WRITE]
                                         : curWrite;
  wire preIo    = (state == `CBL_ST_TI) ? head[`CBL_F_IO] : curIo;
  wire preFetch = (state == `CBL_ST_TI) ? headFetch : curFetch;
  wire [2:0] statusPre = preFetch ? `CBL_CS_FETCH :
                         preIo    ? (preWrite ? `CBL_CS_WRIO
                                              : `CBL_CS_RDIO) :
                         (preWrite ? `CBL_CS_WRMEM : `CBL_CS_RDMEM);

  // status lines and upper byte enable, timed around T1 and T4
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cycleStatus       <= `CBL_CS_IDLE;
      upperByteEnable_n <= 1'b1;
      byteSelectLsb     <= 1'b0;
      addrHigh          <= 4'h0;
    end else begin
      if (next_state == `CBL_ST_TP) begin
        cycleStatus <= `CBL_CS_IDLE;
      end
      if (state == `CBL_ST_TP) begin
        cycleStatus <= cycleStatus;
      end
      if (next_state == `CBL_ST_T1) begin
        cycleStatus <= cycleStatus;
      end
      if ((state == `CBL_ST_T3 || state == `CBL_ST_TW) &&
          endNext) begin
        cycleStatus <= cycleStatus;
      end
      if (state == `CBL_ST_TP || next_state == `CBL_ST_TP) begin
        cycleStatus <= (next_state == `CBL_ST_TP) ? statusPre
                                                  : cycleStatus;
      end
      if ((next_state == `CBL_ST_T3 || next_state == `CBL_ST_TW)
          && readySync) begin
        cycleStatus <= `CBL_CS_IDLE;
      end
      if (next_state == `CBL_ST_TP) begin
        upperByteEnable_n <= ~preUpper;
        byteSelectLsb     <= preAddr[0];
        addrHigh          <= preAddr[19:16];
      end
    end
  end

  // address/data pins: address in T1, data in T2..T4
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      adOut  <= 16'h0000;
      adOe_n <= 1'b1;
    end else begin
      case (next_state)
        `CBL_ST_T1: begin
          adOut  <= curAddr[15:0];
          adOe_n <= 1'b0;
        end
        `CBL_ST_T2: begin
          adOe_n <= ~curWrite;
          if (wordBoth) begin
            adOut <= curData;
          end else if (splitSecond) begin
            adOut <= {curData[15:8], curData[15:8]};
          end else begin
            adOut <= {curData[7:0], curData[7:0]};
          end
        end
        `CBL_ST_T3, `CBL_ST_TW, `CBL_ST_T4: begin
          adOut  <= adOut;
          adOe_n <= adOe_n;
        end
        default: begin
          adOut  <= adOut;
          adOe_n <= 1'b1;
        end
      endcase
    end
  end

  // read data from the used lane only
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      rdData  <= 16'h0000;
    end else begin
      rdValid <= 1'b0;
      if (next_state == `CBL_ST_T4 && !curWrite && !splitFirst) begin
        rdValid <= 1'b1;
        if (wordBoth) begin
          rdData <= adSync;
        end else if (splitSecond) begin
          rdData <= {adSync[7:0], lowHalf};
        end else if (useUpper) begin
          rdData <= {8'h00, adSync[15:8]};
        end else begin
          rdData <= {8'h00, adSync[7:0]};
        end
      end
    end
  end

  // bus lock: on at T1 of first locked data cycle,
  // off three T states after the last one starts, waits or not
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      lockActive <= 1'b0;
      lock_n     <= 1'b1;
      relCnt     <= 2'h0;
    end else begin
      if (next_state == `CBL_ST_T1 && curLock && !curFetch) begin
        lockActive <= 1'b1;
        lock_n     <= 1'b0;
        if (curLast && !splitFirst) begin
          relCnt <= `CBL_LOCK_REL;
        end
      end else if (relCnt != 2'h0) begin
        relCnt <= relCnt - 2'h1;
        if (relCnt == 2'h1) begin
          lockActive <= 1'b0;
          lock_n     <= 1'b1;
        end
      end
    end
  end

  // hold and dma grants, refused while locked
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      holdAck  <= 1'b0;
      dmaGrant <= 1'b0;
    end else begin
      if (holdAck) begin
        holdAck <= holdSync;
      end else if (state == `CBL_ST_TI && !pop && !dmaGrant
                   && holdNow) begin
        holdAck <= 1'b1;
      end
      if (dmaGrant) begin
        dmaGrant <= dmaReq;
      end else if (state == `CBL_ST_TI && !pop && !holdAck
                   && !holdNow && dmaNow) begin
        dmaGrant <= 1'b1;
      end
    end
  end

  wire unusedKind = ^kind ^ useLower ^ activeCode[0] ^ preUpper;
endmodule

// ===== tb/cbl_checker.sv
// assertions on the bus unit ports
`include "cbl_defines.vh"
module cbl_checker (
  input wire logic        ref_clk,           // clock
  input wire logic        rst_n,             // reset
  input wire logic        coprocIdle_n,      // idle pin
  input wire logic        execStall,         // stalled
  input wire logic        holdAck,           // hold grant
  input wire logic        dmaGrant,          // dma grant
  input wire logic [15:0] adOut,             // ad out
  input wire logic        adOe_n,            // ad enable
  input wire logic        byteSelectLsb,     // bit 0
  input wire logic        upperByteEnable_n, // upper lane
  input wire logic [2:0]  cycleStatus,       // status
  input wire logic        lock_n,            // bus lock
  input wire logic        rdValid            // read done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // lock timing against the T1 entry
  property p_lockStart;
    $fell(lock_n) |-> $fell(adOe_n) && cycleStatus != `CBL_CS_FETCH;
  endproperty
  a_lockStart: assert property (p_lockStart)
    else $error("lock start not at T1");
  property p_lockEnd;
    $rose(lock_n) |-> !$past(adOe_n, 3) && $past(adOe_n, 4);
  endproperty
  a_lockEnd: assert property (p_lockEnd)
    else $error("lock release misplaced");
  property p_noFetchLocked;
    cycleStatus == `CBL_CS_FETCH |-> lock_n;
  endproperty
  a_noFetchLocked: assert property (p_noFetchLocked)
    else $error("fetch under lock");
  // no grants under lock, no cycles under grant
  property p_noGrantLocked;
    !lock_n |-> !holdAck && !dmaGrant;
  endproperty
  a_noGrantLocked: assert property (p_noGrantLocked)
    else $error("grant while locked");
  property p_grantQuiet;
    holdAck || dmaGrant |-> cycleStatus == `CBL_CS_IDLE && adOe_n;
  endproperty
  a_grantQuiet: assert property (p_grantQuiet)
    else $error("cycle during grant");
  // status and lane timing
  property p_passiveT4;
    rdValid |-> cycleStatus == `CBL_CS_IDLE && $past(cycleStatus) == 3'h7;
  endproperty
  a_passiveT4: assert property (p_passiveT4)
    else $error("status not passive before T4");
  property p_activeT1;
    $fell(adOe_n) |-> cycleStatus != 3'h7 && $past(cycleStatus) != 3'h7;
  endproperty
  a_activeT1: assert property (p_activeT1)
    else $error("status not active before T1");
  property p_laneEarly;
    $fell(adOe_n) |-> $stable(upperByteEnable_n) && $stable(byteSelectLsb);
  endproperty
  a_laneEarly: assert property (p_laneEarly)
    else $error("lane enable late");
  property p_lanes;
    $fell(adOe_n) |-> adOut[0] == byteSelectLsb
      && !(byteSelectLsb && upperByteEnable_n);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("bad lane select");
  property p_stall;
    $fell(execStall) |-> !$past(coprocIdle_n) || !$past(coprocIdle_n, 2)
      || !$past(coprocIdle_n, 3);
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall ended while busy");
  c_lock: cover property ($fell(lock_n));
  c_read: cover property (rdValid);
  c_hold: cover property ($rose(holdAck));
endmodule

// ===== tb/cbl_mem_model.sv
// memory and ready logic at the far side of the bus
`include "cbl_defines.vh"
module cbl_mem_model (
  input  wire logic        ref_clk,           // clock
  input  wire logic        rst_n,             // reset
  input  wire logic [2:0]  cycleStatus,       // status
  input  wire logic [15:0] adOut,             // ad out
  input  wire logic        adOe_n,            // ad enable
  input  wire logic        byteSelectLsb,     // bit 0
  input  wire logic        upperByteEnable_n, // upper lane
  input  wire logic [3:0]  waits,             // wait states
  output logic      [15:0] adIn,              // read data
  output logic             ready              // cycle may end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:15];
  logic [15:0] junk = 16'h5a5a;
  logic [3:0]  wa, cnt, hold;
  logic        oeLast = 1'b1, t2, wrCyc, rdOn, a0, bhe;
  // one on-board memory, no other master model; the bench raises holdReq
  // and dmaReq, and no cycles reach us while either is granted
  // address taken by our own latch in T1, data a cycle later
  wire idle = cycleStatus == `CBL_CS_IDLE;
  wire isRd = cycleStatus == `CBL_CS_RDMEM || cycleStatus == `CBL_CS_FETCH;
  wire inT1 = !adOe_n && oeLast;
  // answers from the pins in T1, latched address later, junk when released
  assign adIn = rdOn || (inT1 && isRd) ? mem[inT1 ? adOut[4:1] : wa] : junk;
  initial for (int k = 0; k < 16; k++) mem[k] = 16'hc300 | 16'(k);
  // address capture, lane-qualified writes, wait states
  always @(posedge ref_clk) begin
    junk <= ~junk;
    oeLast <= adOe_n;
    t2 <= inT1;
    if (!rst_n) begin
      rdOn <= 1'b0;
      wrCyc <= 1'b0;
      ready <= 1'b1;
      cnt <= 4'h0;
      hold <= 4'h0;
    end else begin
      if (inT1) begin
        wa <= adOut[4:1];
        a0 <= byteSelectLsb;
        bhe <= upperByteEnable_n;
        wrCyc <= !isRd;
        rdOn <= isRd;
      end else if (hold == 4'h3) rdOn <= 1'b0;
      if (t2 && wrCyc && !a0) mem[wa][7:0] <= adOut[7:0];
      if (t2 && wrCyc && !bhe) mem[wa][15:8] <= adOut[15:8];
      hold <= idle ? (hold == 4'hf ? hold : hold + 4'h1) : 4'h0;
      if (!idle && cnt < waits) begin
        ready <= 1'b0;
        cnt <= cnt + 4'h1;
      end else begin
        ready <= 1'b1;
        if (idle) cnt <= 4'h0;
      end
    end
  end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the bus cycle unit
`include "cbl_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
  logic reqWord = 1'b0, reqFetch = 1'b0, reqLast = 1'b1, lockPrefix = 1'b0;
  logic instrEnd = 1'b0, waitInstr = 1'b0, coprocIdle_n = 1'b1;
  logic holdReq = 1'b0, dmaReq = 1'b0;
  logic [19:0] reqAddr = 20'h0_0000;
  logic [15:0] reqWrData = 16'h0000;
  logic [3:0]  waits = 4'h0;
  wire reqReady, execStall, holdAck, dmaGrant, ready, adOe_n, rdValid;
  wire byteSelectLsb, upperByteEnable_n, lock_n;
  wire [15:0] adIn, adOut, rdData;
  wire [3:0]  addrHigh;
  wire [2:0]  cycleStatus;
  int n_errors = 0, tests_run = 0, lockCyc = 0;
  logic [15:0] rdQ [$];
  cbl_bus_unit u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqWord(reqWord),
    .reqIo(1'b0), .reqFetch(reqFetch), .reqLast(reqLast),
    .reqAddr(reqAddr), .reqWrData(reqWrData), .lockPrefix(lockPrefix),
    .instrEnd(instrEnd), .waitInstr(waitInstr), .execStall(execStall),
    .coprocIdle_n(coprocIdle_n), .holdReq(holdReq), .holdAck(holdAck),
    .dmaReq(dmaReq), .dmaGrant(dmaGrant), .ready(ready), .adIn(adIn),
    .adOut(adOut), .adOe_n(adOe_n), .addrHigh(addrHigh),
    .byteSelectLsb(byteSelectLsb), .upperByteEnable_n(upperByteEnable_n),
    .cycleStatus(cycleStatus), .lock_n(lock_n), .rdValid(rdValid),
    .rdData(rdData));
  cbl_mem_model u_mem (
    .ref_clk(ref_clk), .rst_n(rst_n), .cycleStatus(cycleStatus),
    .adOut(adOut), .adOe_n(adOe_n), .byteSelectLsb(byteSelectLsb),
    .upperByteEnable_n(upperByteEnable_n), .waits(waits), .adIn(adIn),
    .ready(ready));
  always #12.5 ref_clk = ~ref_clk;
  // collect read results and locked cycles
  always @(posedge ref_clk) begin
    if (rdValid === 1'b1) rdQ.push_back(rdData);
    if (lock_n === 1'b0) lockCyc++;
  end
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR t=%0t %s", $time, msg);
    end
  endtask
  // offer one request, held until taken; caller drops reqValid
  task automatic req(input logic wr, wd, fe, input logic [19:0] a,
                     input logic [15:0] d);
    reqValid = 1'b1;
    reqWrite = wr;
    reqWord = wd;
    reqFetch = fe;
    reqAddr = a;
    reqWrData = d;
    while (reqReady !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic wd, fe, input logic [19:0] a,
                    input logic [15:0] exp, mask);
    rdQ.delete();
    req(1'b0, wd, fe, a, 16'h0000);
    reqValid = 1'b0;
    for (int i = 0; i < 300 && rdQ.size() == 0; i++) @(negedge ref_clk);
    check((rdQ[0] & mask) === exp, "read data");
  endtask
  task automatic t_lanes;
    req(1'b1, 1'b0, 1'b0, 20'h0_0002, 16'h0011);
    req(1'b1, 1'b0, 1'b0, 20'h0_0005, 16'h0022);
    req(1'b1, 1'b1, 1'b0, 20'h0_0006, 16'h4433);
    req(1'b1, 1'b1, 1'b0, 20'h0_0009, 16'h6655);
    for (int p = 0; p < 2; p++) begin
      waits = 4'(p * 3);
      rd(1'b1, 1'b0, 20'h0_0002, 16'hc311, 16'hffff);
      rd(1'b0, 1'b0, 20'h0_0005, 16'h0022, 16'h00ff);
      rd(1'b1, 1'b0, 20'h0_0006, 16'h4433, 16'hffff);
      rd(1'b1, 1'b0, 20'h0_0009, 16'h6655, 16'hffff);
      rd(1'b1, 1'b0, 20'h0_0008, 16'h5504, 16'hffff);
      rd(1'b1, 1'b0, 20'h0_000a, 16'hc366, 16'hffff);
    end
    $display("test lanes done");
  endtask
  task automatic t_lock;
    waits = 4'h3;
    lockPrefix = 1'b1;
    @(negedge ref_clk);
    lockPrefix = 1'b0;
    reqLast = 1'b0;
    req(1'b1, 1'b1, 1'b0, 20'h0_000c, 16'h7788);
    reqLast = 1'b1;
    req(1'b1, 1'b1, 1'b0, 20'h0_000e, 16'h99aa);
    reqValid = 1'b0;
    instrEnd = 1'b1;
    @(negedge ref_clk);
    instrEnd = 1'b0;
    holdReq = 1'b1;
    for (int i = 0; i < 400 && holdAck !== 1'b1; i++) @(negedge ref_clk);
    check(lockCyc > 0, "no locked cycles");
    check(holdAck === 1'b1, "hold never granted");
    holdReq = 1'b0;
    lockCyc = 0;
    rd(1'b1, 1'b1, 20'h0_000c, 16'h7788, 16'hffff);
    check(lockCyc == 0, "lock after instruction end");
    waits = 4'h0;
    $display("test lock done");
  endtask
  task automatic t_wait;
    waitInstr = 1'b1;
    @(negedge ref_clk);
    waitInstr = 1'b0;
    repeat (20) @(negedge ref_clk);
    check(execStall === 1'b1, "stall ended early");
    coprocIdle_n = 1'b0;
    for (int i = 0; i < 8 && execStall !== 1'b0; i++) @(negedge ref_clk);
    check(execStall === 1'b0, "stall stuck");
    coprocIdle_n = 1'b1;
    $display("test wait done");
  endtask
  task automatic t_dma;
    dmaReq = 1'b1;
    for (int i = 0; i < 20 && dmaGrant !== 1'b1; i++) @(negedge ref_clk);
    check(dmaGrant === 1'b1, "dma not granted");
    req(1'b1, 1'b0, 1'b0, 20'h0_0010, 16'h00bb);
    reqValid = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(cycleStatus === `CBL_CS_IDLE, "cycle during dma");
    dmaReq = 1'b0;
    rd(1'b0, 1'b0, 20'h0_0010, 16'h00bb, 16'h00ff);
    $display("test dma done");
  endtask
  task automatic t_fill;
    waits = 4'h4;
    rdQ.delete();
    holdReq = 1'b1;
    for (int i = 0; i < 50 && holdAck !== 1'b1; i++) @(negedge ref_clk);
    for (int k = 0; k < 8; k++) req(1'b0, 1'b0, 1'b0, 20'h0_0018 + 20'(k), 16'h0000);
    reqValid = 1'b0;
    @(negedge ref_clk);
    check(reqReady === 1'b0, "queue accepts ninth");
    holdReq = 1'b0;
    for (int i = 0; i < 2000 && rdQ.size() < 8; i++) @(negedge ref_clk);
    check(rdQ.size() == 8, "drain count");
    for (int k = 0; k < 8; k++)
      check((rdQ[k] & 16'h00ff) === (k[0] ? 16'h00c3 : 16'(12 + k / 2)),
            "drain data");
    $display("test fill done");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_lanes;
    t_lock;
    t_wait;
    t_dma;
    t_fill;
    summarize;
  end
  // watchdog against a hang
  initial begin
    #(25 * 40000);
    n_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    summarize;
  end
endmodule
bind cbl_bus_unit cbl_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .coprocIdle_n(coprocIdle_n),
  .execStall(execStall), .holdAck(holdAck), .dmaGrant(dmaGrant),
  .adOut(adOut), .adOe_n(adOe_n), .byteSelectLsb(byteSelectLsb),
  .upperByteEnable_n(upperByteEnable_n), .cycleStatus(cycleStatus),
  .lock_n(lock_n), .rdValid(rdValid));
